/* rtl/arf_map.svh */
// register offsets, field positions, reset values and timing counts of the result formatter
`ifndef ARF_MAP_SVH
`define ARF_MAP_SVH
`define ARF_OFF_CTRL_ZERO    8'h00
`define ARF_OFF_CTRL_ONE     8'h04
`define ARF_OFF_TRIG_CTRL    8'h08
`define ARF_OFF_RES_HIGH     8'h0c
`define ARF_OFF_RES_LOW      8'h10
`define ARF_OFF_IRQ_STATUS   8'h14
`define ARF_OFF_IRQ_MASK     8'h18
`define ARF_OFF_BOR_CTRL     8'h1c
`define ARF_BIT_ON           0
`define ARF_BIT_GO           1
`define ARF_CHS_LSB          2
`define ARF_CHS_MSB          6
`define ARF_BIT_JUSTIFY      7
`define ARF_CTRL_ZERO_MASK   8'h7f
`define ARF_CTRL_ONE_MASK    8'hf3
`define ARF_TRIG_MASK        8'hf8
`define ARF_CTRL_RESET       8'h00
`define ARF_IRQ_DONE_BIT     0
`define ARF_CONV_TIME_NS     1000
`define ARF_CLK_PERIOD_NS    10
`define ARF_CONV_CYCLES      (`ARF_CONV_TIME_NS / `ARF_CLK_PERIOD_NS)
`define ARF_RESP_OKAY        2'b00
`define ARF_RESP_SLVERR      2'b10
`endif

/* rtl/arf_pkg.sv */
// types of the result formatter
package arf_pkg;
   typedef enum logic [0:0] {
      ARF_IDLE,
      ARF_CONVERT
   } arf_conv_state_t;

   typedef struct packed {
      arf_conv_state_t conv_st;
      logic [7:0]      ctrl_zero;
      logic [7:0]      ctrl_one;
      logic [7:0]      trig_ctrl;
      logic [7:0]      res_high;
      logic [7:0]      res_low;
      logic [0:0]      irq_status;
      logic [0:0]      irq_mask;
      logic [15:0]     conv_cnt;
      logic            aw_held;
      logic [7:0]      aw_addr;
      logic            w_held;
      logic [31:0]     w_data;
      logic [3:0]      w_strb;
      logic            bvalid;
      logic [1:0]      bresp;
      logic            rvalid;
      logic [31:0]     rdata;
      logic [1:0]      rresp;
   } arf_state_t;
endpackage

/* rtl/arf_result_formatter.sv */
// result path of a 10-bit converter: justification, result registers, start/done bit
`timescale 1ns/100ps
`include "arf_map.svh"

// What this block does
// [RULE1] left justified: result bits 9..2 fill all of the high result byte
// [RULE2] left justified: result bits 1..0 go to low byte bits 7..6
// [RULE3] left justified: low byte bits 5..0 are zeroed on every result load
// [RULE4] right justified: result bits 9..8 go to high byte bits 1..0
// [RULE5] right justified: high byte bits 7..2 are zeroed on every result load
// [RULE6] right justified: result bits 7..0 fill all of the low result byte
// [RULE7] result bytes are read/write; unknown after power-on, kept over other resets
// [RULE8] software waits one acquisition period after a channel change before starting
// [RULE9] writing 1 to the status bit starts; hardware clears it when done (here a start also needs the on bit set in the same write)
// [RULE10] both result bytes load in the same cycle the status bit clears
module arf_result_formatter #(
   parameter int unsigned CONV_CYCLES = `ARF_CONV_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        por_rst,
   input  wire logic [9:0]  conversion_result,
   output logic             conv_start,
   output logic [4:0]       input_channel_select,
   output logic             converter_on,
   output logic             irq,
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   import arf_pkg::*;

   // =====================================================
   // state
   arf_state_t st_q;
   arf_state_t st_d;
   // result bytes live outside the reset struct: only power-on touches them
   logic [7:0] res_high_q;
   logic [7:0] res_low_q;
   logic [7:0] res_high_d;
   logic [7:0] res_low_d;

   logic       wr_fire;
   logic       rd_fire;
   logic       done;
   logic       justify;
   logic [7:0] wbyte;
   logic [7:0] fmt_high;
   logic [7:0] fmt_low;

   assign justify = st_q.ctrl_one[`ARF_BIT_JUSTIFY];

   // =====================================================
   // justification of the raw result
   always_comb begin
      if (justify) begin
         fmt_high = {6'h00, conversion_result[9:8]}; // [RULE4] [RULE5]
         fmt_low  = conversion_result[7:0]; // [RULE6]
      end else begin
         fmt_high = conversion_result[9:2]; // [RULE1]
         fmt_low  = {conversion_result[1:0], 6'h00}; // [RULE2] [RULE3]
      end
   end

   // =====================================================
   // bus handshakes
   assign s_axi_awready = !st_q.aw_held && !st_q.bvalid;
   assign s_axi_wready  = !st_q.w_held && !st_q.bvalid;
   assign s_axi_arready = !st_q.rvalid;
   assign wr_fire       = st_q.aw_held && st_q.w_held && !st_q.bvalid;
   assign rd_fire       = s_axi_arvalid && !st_q.rvalid;
   assign wbyte         = st_q.w_strb[0] ? st_q.w_data[7:0] : 8'h00;
   assign done          = (st_q.conv_st == ARF_CONVERT) &&
                          (st_q.conv_cnt == 16'(CONV_CYCLES - 1));

   // =====================================================
   // next state
   always_comb begin
      st_d       = st_q;
      res_high_d = res_high_q;
      res_low_d  = res_low_q;
      conv_start = 1'b0;

      if (s_axi_awvalid && s_axi_awready) begin
         st_d.aw_held = 1'b1;
         st_d.aw_addr = s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
         st_d.w_held = 1'b1;
         st_d.w_data = s_axi_wdata;
         st_d.w_strb = s_axi_wstrb;
      end
      if (st_q.bvalid && s_axi_bready) begin
         st_d.bvalid = 1'b0;
      end

      // conversion timer
      unique case (st_q.conv_st)
         ARF_IDLE: begin
            st_d.conv_cnt = 16'h0000;
         end
         ARF_CONVERT: begin
            st_d.conv_cnt = st_q.conv_cnt + 16'h0001;
            if (done) begin
               st_d.conv_st = ARF_IDLE;
               st_d.ctrl_zero[`ARF_BIT_GO] = 1'b0; // [RULE9] [RULE10]
               res_high_d = fmt_high; // [RULE10]
               res_low_d  = fmt_low; // [RULE10]
               st_d.irq_status[`ARF_IRQ_DONE_BIT] = 1'b1;
            end
         end
      endcase

      // register writes
      if (wr_fire) begin
         st_d.aw_held = 1'b0;
         st_d.w_held  = 1'b0;
         st_d.bvalid  = 1'b1;
         st_d.bresp   = `ARF_RESP_OKAY;
         unique case ({st_q.aw_addr[7:2], 2'b00})
            `ARF_OFF_CTRL_ZERO: begin
               if (st_q.w_strb[0]) begin
                  st_d.ctrl_zero = wbyte & `ARF_CTRL_ZERO_MASK;
                  // writing 0 aborts; a start only counts while the converter is on
                  if (wbyte[`ARF_BIT_GO] && wbyte[`ARF_BIT_ON] &&
                      st_q.conv_st == ARF_IDLE) begin
                     st_d.conv_st  = ARF_CONVERT; // [RULE9]
                     st_d.conv_cnt = 16'h0000;
                     conv_start    = 1'b1;
                  end else if (st_q.conv_st == ARF_CONVERT && !done &&
                               wbyte[`ARF_BIT_GO] && wbyte[`ARF_BIT_ON]) begin
                     st_d.ctrl_zero[`ARF_BIT_GO] = 1'b1; // [RULE9]
                  end else begin
                     st_d.ctrl_zero[`ARF_BIT_GO] = 1'b0;
                     st_d.conv_st = ARF_IDLE;
                  end
               end
            end
            `ARF_OFF_CTRL_ONE: begin
               if (st_q.w_strb[0]) st_d.ctrl_one = wbyte & `ARF_CTRL_ONE_MASK;
            end
            `ARF_OFF_TRIG_CTRL: begin
               if (st_q.w_strb[0]) st_d.trig_ctrl = wbyte & `ARF_TRIG_MASK;
            end
            `ARF_OFF_RES_HIGH: begin
               // a completing conversion overrides a same-cycle software write
               if (st_q.w_strb[0] && !done) res_high_d = wbyte; // [RULE7]
            end
            `ARF_OFF_RES_LOW: begin
               if (st_q.w_strb[0] && !done) res_low_d = wbyte; // [RULE7]
            end
            `ARF_OFF_IRQ_STATUS: begin
               // set wins over clear
               if (st_q.w_strb[0] && wbyte[0] && !done) st_d.irq_status = 1'b0;
            end
            `ARF_OFF_IRQ_MASK: begin
               if (st_q.w_strb[0]) st_d.irq_mask = wbyte[0];
            end
            default: begin
               st_d.bresp = `ARF_RESP_SLVERR;
            end
         endcase
      end

      // register reads
      if (st_q.rvalid && s_axi_rready) begin
         st_d.rvalid = 1'b0;
      end
      if (rd_fire) begin
         st_d.rvalid = 1'b1;
         st_d.rresp  = `ARF_RESP_OKAY;
         st_d.rdata  = 32'h0000_0000;
         unique case ({s_axi_araddr[7:2], 2'b00})
            `ARF_OFF_CTRL_ZERO:  st_d.rdata[7:0] = st_q.ctrl_zero;
            `ARF_OFF_CTRL_ONE:   st_d.rdata[7:0] = st_q.ctrl_one;
            `ARF_OFF_TRIG_CTRL:  st_d.rdata[7:0] = st_q.trig_ctrl;
            `ARF_OFF_RES_HIGH:   st_d.rdata[7:0] = res_high_q; // [RULE7]
            `ARF_OFF_RES_LOW:    st_d.rdata[7:0] = res_low_q; // [RULE7]
            `ARF_OFF_IRQ_STATUS: st_d.rdata[0]   = st_q.irq_status[0];
            `ARF_OFF_IRQ_MASK:   st_d.rdata[0]   = st_q.irq_mask[0];
            default:             st_d.rresp      = `ARF_RESP_SLVERR;
         endcase
      end
   end

   // =====================================================
   // registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q            <= '0;
         st_q.conv_st    <= ARF_IDLE;
         st_q.ctrl_zero  <= `ARF_CTRL_RESET;
         st_q.ctrl_one   <= `ARF_CTRL_RESET;
         st_q.trig_ctrl  <= `ARF_CTRL_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   // power-on reset only: no defined value, other resets leave the bytes alone
   always_ff @(posedge clk) begin
      if (por_rst) begin
         res_high_q <= 8'hxx; // [RULE7]
         res_low_q  <= 8'hxx; // [RULE7]
      end else begin
         res_high_q <= res_high_d;
         res_low_q  <= res_low_d;
      end
   end

   // =====================================================
   // outputs
   assign converter_on         = st_q.ctrl_zero[`ARF_BIT_ON];
   assign input_channel_select = st_q.ctrl_zero[`ARF_CHS_MSB:`ARF_CHS_LSB];
   assign irq                  = |(st_q.irq_status & st_q.irq_mask);
   assign s_axi_bvalid         = st_q.bvalid;
   assign s_axi_bresp          = st_q.bresp;
   assign s_axi_rvalid         = st_q.rvalid;
   assign s_axi_rdata          = st_q.rdata;
   assign s_axi_rresp          = st_q.rresp;
endmodule

/* test/arf_result_formatter_bench.sv */
// self-checking bench of the result formatter with an integer result model
`timescale 1ns/100ps
module arf_result_formatter_bench;
   logic        clk, rst, por_rst, conv_start, converter_on, irq;
   logic [9:0]  conversion_result;
   logic [4:0]  input_channel_select, ch;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, j;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   int          n_errors, cmp_count, seed, eh, el, v, n;
   arf_result_formatter #(.CONV_CYCLES(4)) u_dut (.*);
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ==========
   // bus tasks and checking
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test;
      $display("errors %0d comparisons %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // ready/valid looked at mid-cycle; the handshake itself lands on the next rising edge
   task automatic wr(input logic [7:0] a, input logic [7:0] dat);
      logic ta, tw, tb;
      {ta, tw, tb} = 3'b0;
      @(posedge clk);
      s_axi_awaddr <= {24'h0, a};
      s_axi_wdata <= {24'h0, dat};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!tb) begin
         @(negedge clk);
         ta |= s_axi_awready;
         tw |= s_axi_wready;
         tb = s_axi_bvalid;
         @(posedge clk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (tb) s_axi_bready <= 1'b0;
      end
   endtask
   task automatic rd(input logic [7:0] a);
      logic ta, tr;
      {ta, tr} = 2'b0;
      @(posedge clk);
      s_axi_araddr <= {24'h0, a};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!tr) begin
         @(negedge clk);
         ta |= s_axi_arready;
         tr = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge clk);
         if (ta) s_axi_arvalid <= 1'b0;
         if (tr) s_axi_rready <= 1'b0;
      end
   endtask
   initial begin
      #200000;
      n_errors++;
      stop_test();
   end
   // ==========
   // main sequence
   initial begin
      seed = 32'h28262cd8;
      {rst, por_rst, conversion_result, s_axi_wstrb} = {2'b10, 10'h0, 4'hf};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
      {n_errors, cmp_count} = 64'h0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      por_rst <= 1'b1;
      @(posedge clk);
      por_rst <= 1'b0;
      rd(8'h0c);
      chk(d, 32'h000000xx);
      $display("power-on test done");
      for (int k = 0; k < 8; k++) begin
         v = (k < 4) ? {10{k[1]}} : 10'($random(seed));
         j = k[0];
         ch = 5'($random(seed));
         wr(8'h0c, 8'hff);
         wr(8'h10, 8'hff);
         wr(8'h04, {j, 7'h0});
         wr(8'h00, {1'b0, ch, 2'b01});
         conversion_result <= 10'(v);
         repeat (8) @(posedge clk);
         chk({27'h0, input_channel_select}, {27'h0, ch});
         wr(8'h00, {1'b0, ch, 2'b11});
         rd(8'h00);
         for (n = 0; d[1] === 1'b1 && n < 20; n++)
            rd(8'h00);
         chk(d, {24'h0, 1'b0, ch, 2'b01});
         eh = j ? v / 256 : v / 4;
         el = j ? v % 256 : (v % 4) * 64;
         rd(8'h0c);
         chk(d, 32'(eh));
         rd(8'h10);
         chk(d, 32'(el));
      end
      $display("conversion test done");
      rd(8'h14);
      chk(d, 32'h1);
      chk({31'h0, irq}, 32'h0);
      wr(8'h18, 8'h01);
      chk({31'h0, irq}, 32'h1);
      wr(8'h14, 8'h01);
      chk({31'h0, irq}, 32'h0);
      rd(8'h1c);
      chk({30'h0, r}, 32'h2);
      $display("interrupt and unmapped test done");
      v = $random(seed);
      wr(8'h10, 8'(v));
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rd(8'h10);
      chk(d, {24'h0, 8'(v)});
      rd(8'h0c);
      chk(d, 32'(eh));
      chk({31'h0, converter_on}, 32'h0);
      $display("warm reset test done");
      stop_test();
   end
endmodule
bind arf_result_formatter arf_props u_props (.*);

/* test/arf_result_formatter_properties.sv */
// concurrent checks on the formatter's bus and start ports
`timescale 1ns/100ps
module arf_props (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        conv_start,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   wr_resp_a:
      assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid) else $error("write response late");
   b_hold_a:
      assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("write response dropped");
   rd_resp_a:
      assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");
   r_hold_a:
      assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read data dropped");
   ar_block_a:
      assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while busy");
   aw_block_a:
      assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while busy");
   rd_upper_a:
      assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper read bits set");
   start_pulse_a:
      assert property (conv_start |=> !conv_start)
      else $error("start longer than one cycle");
   cover property (conv_start);
   cover property (s_axi_bvalid && !s_axi_bready);
   cover property (s_axi_rvalid && !s_axi_rready);
endmodule
